// >>> oir_pkg.sv
// Shared constants and carrier types for the interrupt-disable/comm-area bank
package oir_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_INT_CLEAR = 8'h14;
  localparam logic [7:0] OFF_COMM_BASE = 8'h18;
  localparam logic [7:0] OFF_PERIODIC_CUR = 8'h1C;
  localparam int BIT_MASTER = 31;
  localparam int BIT_OWNERSHIP = 30;
  localparam int BIT_ROOT_HUB = 6;
  localparam int BIT_FRAME_OVF = 5;
  localparam int BIT_UNRECOV = 4;
  localparam int BIT_RESUME = 3;
  localparam int BIT_SOF = 2;
  localparam int BIT_DONE_WB = 1;
  localparam int BIT_OVERRUN = 0;
  // Implemented enable bits: 31, 30 and 6..0
  localparam logic [31:0] ENABLE_IMPL_MASK = 32'hC000007F;
  localparam logic [31:0] ENABLE_RESET = 32'h00000000;
  localparam logic [31:0] COMM_BASE_MASK = 32'hFFFFFF00;
  localparam logic [31:0] COMM_BASE_RESET = 32'h00000000;
  localparam logic [31:0] PERIODIC_MASK = 32'hFFFFFFF0;
  localparam logic [31:0] PERIODIC_RESET = 32'h00000000;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [31:0] wrData;
  } oir_req_t;

  typedef struct packed {
    logic rdValid;
    logic [31:0] rdData;
  } oir_rsp_t;

  typedef struct packed {
    logic setEn;
    logic [31:0] setBits;
    logic edDone;
    logic [31:0] edAddr;
  } oir_core_t;
endpackage

// >>> oir_regs.sv
// Interrupt-enable clear alias, comm-area base and periodic pointer registers
`timescale 1ns/1ps
module oir_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic swReset,
  input wire oir_pkg::oir_req_t req,
  input wire oir_pkg::oir_core_t core,
  output oir_pkg::oir_rsp_t rsp,
  output logic [31:0] intEnable,
  output logic [31:0] commAreaBaseAddress
);

  logic [31:0] enableReg;
  logic [31:0] commBase;
  logic [31:0] periodicCur;
  logic [31:0] next_enable;
  logic [31:0] rdMux;

  wire hitClear = req.addr == oir_pkg::OFF_INT_CLEAR;
  wire hitComm = req.addr == oir_pkg::OFF_COMM_BASE;
  wire hitPeriodic = req.addr == oir_pkg::OFF_PERIODIC_CUR;
  wire wrClear = req.wrEn && hitClear;
  wire wrComm = req.wrEn && hitComm;
  // Only set bits of the write clear enables; zeros keep them
  wire [31:0] clearBits = wrClear ?
    (req.wrData & oir_pkg::ENABLE_IMPL_MASK) : 32'h00000000;
  wire [31:0] setBits = core.setEn ?
    (core.setBits & oir_pkg::ENABLE_IMPL_MASK) : 32'h00000000;

  // Clear wins over a same-cycle set coming from the enable-set alias,
  // so a disable issued by software is never undone silently
  assign next_enable = (enableReg | setBits) & ~clearBits;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enableReg <= oir_pkg::ENABLE_RESET;
    end else if (swReset) begin
      enableReg <= oir_pkg::ENABLE_RESET;
    end else begin
      enableReg <= next_enable;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      commBase <= oir_pkg::COMM_BASE_RESET;
    end else if (swReset) begin
      commBase <= oir_pkg::COMM_BASE_RESET;
    end else if (wrComm) begin
      commBase <= req.wrData & oir_pkg::COMM_BASE_MASK;
    end
  end

  // Writes to this offset are ignored; only the schedule moves it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      periodicCur <= oir_pkg::PERIODIC_RESET;
    end else if (swReset) begin
      periodicCur <= oir_pkg::PERIODIC_RESET;
    end else if (core.edDone) begin
      periodicCur <= core.edAddr & oir_pkg::PERIODIC_MASK;
    end
  end

  // Offsets decode one-hot, so the read select is a plain OR
  wire [31:0] rdClear = hitClear ? enableReg : 32'h00000000;
  wire [31:0] rdComm = hitComm ? commBase : 32'h00000000;
  wire [31:0] rdPeriodic = hitPeriodic ? periodicCur : 32'h00000000;
  assign rdMux = rdClear | rdComm | rdPeriodic;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp <= '0;
      intEnable <= oir_pkg::ENABLE_RESET;
      commAreaBaseAddress <= oir_pkg::COMM_BASE_RESET;
    end else begin
      rsp.rdValid <= req.rdEn;
      rsp.rdData <= req.rdEn ? rdMux : 32'h00000000;
      intEnable <= swReset ? oir_pkg::ENABLE_RESET : next_enable;
      commAreaBaseAddress <= swReset ? oir_pkg::COMM_BASE_RESET :
        (wrComm ? (req.wrData & oir_pkg::COMM_BASE_MASK) : commBase);
    end
  end

  // Enable clear path
  AST_MASTER_CLEAR: assert property (
    @(posedge ref_clk) disable iff (rst)
    wrClear && req.wrData[oir_pkg::BIT_MASTER]
    |=> !enableReg[oir_pkg::BIT_MASTER] && !intEnable[oir_pkg::BIT_MASTER])
    else $error("master enable not cleared");

  AST_OWNER_CLEAR: assert property (
    @(posedge ref_clk) disable iff (rst)
    wrClear && req.wrData[oir_pkg::BIT_OWNERSHIP]
    |=> !enableReg[oir_pkg::BIT_OWNERSHIP])
    else $error("ownership enable not cleared");

  AST_LOW_CLEAR: assert property (
    @(posedge ref_clk) disable iff (rst)
    wrClear
    |=> ((enableReg[6:4] & $past(req.wrData[6:4])) == 3'h0))
    else $error("status enables not cleared");

  AST_MID_CLEAR: assert property (
    @(posedge ref_clk) disable iff (rst)
    wrClear
    |=> ((enableReg[3:0] & $past(req.wrData[3:0])) == 4'h0))
    else $error("frame enables not cleared");

  AST_OVERRUN_CLEAR: assert property (
    @(posedge ref_clk) disable iff (rst)
    wrClear && req.wrData[oir_pkg::BIT_OVERRUN]
    |=> !enableReg[oir_pkg::BIT_OVERRUN])
    else $error("overrun enable not cleared");

  AST_CLEAR_WINS: assert property (
    @(posedge ref_clk) disable iff (rst)
    wrClear && core.setEn
    |=> (enableReg & $past(clearBits)) == 32'h00000000)
    else $error("same-cycle set undid a clear");

  // Zero writes, set alias and resets
  AST_ZERO_KEEPS: assert property (
    @(posedge ref_clk) disable iff (rst)
    wrClear && !core.setEn && !swReset && req.wrData == 32'h0
    |=> $stable(enableReg))
    else $error("zero write changed enable");

  AST_HOLD_IDLE: assert property (
    @(posedge ref_clk) disable iff (rst)
    !wrClear && !core.setEn && !swReset
    |=> $stable(enableReg))
    else $error("enable changed without a write");

  AST_SET_ALIAS: assert property (
    @(posedge ref_clk) disable iff (rst)
    core.setEn && !wrClear && !swReset
    |=> (enableReg & $past(setBits)) == $past(setBits))
    else $error("set alias bits not stored");

  AST_SW_RESET: assert property (
    @(posedge ref_clk) disable iff (rst)
    swReset
    |=> !enableReg[oir_pkg::BIT_MASTER] && commBase == 32'h0)
    else $error("software reset left state");

  AST_SW_RESET_OUT: assert property (
    @(posedge ref_clk) disable iff (rst)
    swReset
    |=> intEnable == 32'h0 && commAreaBaseAddress == 32'h0
        && periodicCur == 32'h0)
    else $error("software reset left outputs set");

  // Read path and enable output copy
  AST_READ_ALIAS: assert property (
    @(posedge ref_clk) disable iff (rst)
    req.rdEn && hitClear
    |=> rsp.rdValid && rsp.rdData == $past(enableReg))
    else $error("clear read not enable value");

  AST_OUT_MIRROR: assert property (
    @(posedge ref_clk) disable iff (rst)
    intEnable == enableReg)
    else $error("enable output copy diverged");

  AST_RD_PULSE: assert property (
    @(posedge ref_clk) disable iff (rst)
    1'b1 |=> rsp.rdValid == $past(req.rdEn))
    else $error("read valid not one cycle after strobe");

  AST_IDLE_ZERO: assert property (
    @(posedge ref_clk) disable iff (rst)
    !rsp.rdValid |-> rsp.rdData == 32'h0)
    else $error("read data nonzero while idle");

  AST_UNMAPPED: assert property (
    @(posedge ref_clk) disable iff (rst)
    req.rdEn && !hitClear && !hitComm && !hitPeriodic
    |=> rsp.rdValid && rsp.rdData == 32'h0)
    else $error("unmapped read not zero");

  // Comm-area base
  AST_COMM_WRITE: assert property (
    @(posedge ref_clk) disable iff (rst)
    wrComm && !swReset
    |=> commBase[31:8] == $past(req.wrData[31:8]))
    else $error("comm base not stored");

  AST_COMM_HOLD: assert property (
    @(posedge ref_clk) disable iff (rst)
    !wrComm && !swReset
    |=> $stable(commBase))
    else $error("comm base changed without a write");

  AST_COMM_READ: assert property (
    @(posedge ref_clk) disable iff (rst)
    req.rdEn && hitComm
    |=> rsp.rdData == $past(commBase))
    else $error("comm base read wrong");

  AST_COMM_LOW: assert property (
    @(posedge ref_clk) disable iff (rst)
    rsp.rdValid && $past(hitComm)
    |-> rsp.rdData[7:0] == 8'h00)
    else $error("comm base low bits nonzero");

  AST_COMM_MASKED: assert property (
    @(posedge ref_clk) disable iff (rst)
    wrComm && !swReset
    |=> commBase == ($past(req.wrData) & oir_pkg::COMM_BASE_MASK))
    else $error("comm base stored low bits");

  AST_COMM_ZERO_STORE: assert property (
    @(posedge ref_clk) disable iff (rst)
    commBase[7:0] == 8'h00)
    else $error("comm base holds low bits");

  AST_COMM_MIRROR: assert property (
    @(posedge ref_clk) disable iff (rst)
    commAreaBaseAddress == commBase)
    else $error("comm base output copy diverged");

  // Periodic pointer
  AST_PERIODIC_UPD: assert property (
    @(posedge ref_clk) disable iff (rst)
    core.edDone && !swReset
    |=> periodicCur == ($past(core.edAddr) & oir_pkg::PERIODIC_MASK))
    else $error("periodic pointer not updated");

  AST_PERIODIC_HOLD: assert property (
    @(posedge ref_clk) disable iff (rst)
    !core.edDone && !swReset
    |=> $stable(periodicCur))
    else $error("periodic pointer moved on its own");

  AST_PERIODIC_RO: assert property (
    @(posedge ref_clk) disable iff (rst)
    req.wrEn && hitPeriodic && !core.edDone && !swReset
    |=> $stable(periodicCur))
    else $error("periodic pointer written");

  AST_PERIODIC_READ: assert property (
    @(posedge ref_clk) disable iff (rst)
    req.rdEn && hitPeriodic
    |=> rsp.rdData == $past(periodicCur))
    else $error("periodic pointer read wrong");

  AST_PERIODIC_LOW: assert property (
    @(posedge ref_clk) disable iff (rst)
    periodicCur[3:0] == 4'h0)
    else $error("periodic pointer low bits nonzero");

  // Per-bit view of the enable register
  for (genvar b = 0; b < 32; b++) begin : g_bit_chk
    if (oir_pkg::ENABLE_IMPL_MASK[b]) begin : g_impl
      AST_BIT_CLEAR: assert property (
        @(posedge ref_clk) disable iff (rst)
        wrClear && req.wrData[b]
        |=> !enableReg[b] && !intEnable[b])
        else $error("enable bit not cleared");

      AST_BIT_KEEP: assert property (
        @(posedge ref_clk) disable iff (rst)
        wrClear && !req.wrData[b] && !core.setEn && !swReset
        |=> enableReg[b] == $past(enableReg[b]))
        else $error("enable bit changed by zero write");

      AST_BIT_SET: assert property (
        @(posedge ref_clk) disable iff (rst)
        core.setEn && core.setBits[b] && !clearBits[b] && !swReset
        |=> enableReg[b])
        else $error("enable bit not set by alias");
    end else begin : g_rsvd
      AST_BIT_RSVD: assert property (
        @(posedge ref_clk) disable iff (rst)
        !enableReg[b] && !intEnable[b])
        else $error("reserved enable bit stored");
    end
  end

  COV_CLEAR_ALL: cover property (@(posedge ref_clk) disable iff (rst)
    enableReg[oir_pkg::BIT_MASTER] ##1 wrClear ##1
    enableReg == 32'h0);
  COV_ALIGN_PROBE: cover property (@(posedge ref_clk) disable iff (rst)
    wrComm && req.wrData == 32'hFFFFFFFF ##1 req.rdEn && hitComm);
  COV_PERIODIC_READ: cover property (@(posedge ref_clk) disable iff (rst)
    core.edDone ##1 req.rdEn && hitPeriodic);
  COV_SET_CLEAR: cover property (@(posedge ref_clk) disable iff (rst)
    core.setEn && wrClear);

endmodule

// >>> oir_regs_test.sv
// Self-checking bench for the enable-clear, comm-area and pointer bank
`timescale 1ns/1ps
module oir_regs_test;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic swReset = 1'b0;
  oir_pkg::oir_req_t req = '0;
  oir_pkg::oir_core_t core = '0;
  oir_pkg::oir_rsp_t rsp;
  logic [31:0] intEnable, commAreaBaseAddress;
  logic [31:0] mEn = '0, mBase = '0, mPtr = '0, mRd = '0, seed = 32'h0000BF4F;
  logic mRv = 1'b0;
  logic [7:0] addrTab [8] = '{8'h14, 8'h18, 8'h1C, 8'h10, 8'h20, 8'h14,
    8'h18, 8'h1C};
  int bits [9] = '{31, 30, 6, 5, 4, 3, 2, 1, 0};
  int n_fail = 0, checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  oir_regs dut_u (.ref_clk(ref_clk), .rst(rst), .swReset(swReset),
    .req(req), .core(core), .rsp(rsp), .intEnable(intEnable),
    .commAreaBaseAddress(commAreaBaseAddress));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Called at a falling edge; compares at the next falling edge, one cycle later, against the model
  task automatic step(input logic wr, rd, input logic [7:0] a,
    input logic [31:0] d, input logic se, input logic [31:0] sb,
    input logic ed, input logic [31:0] ea, input logic sr);
    logic [31:0] clr;
    clr = (wr && a == oir_pkg::OFF_INT_CLEAR) ? d : 32'h00000000;
    req = '{wr, rd, a, d};
    core = '{se, sb, ed, ea};
    swReset = sr;
    mRv = rd;
    mRd = !rd ? 32'h0 : a == 8'h14 ? mEn : a == 8'h18 ? mBase :
      a == 8'h1C ? mPtr : 32'h0;
    // Same-edge set and clear: clear wins
    mEn = sr ? 32'h0 : (mEn | (se ? sb : 32'h0)) & ~clr &
      oir_pkg::ENABLE_IMPL_MASK;
    if (wr && a == oir_pkg::OFF_COMM_BASE) mBase = d & 32'hFFFFFF00;
    if (ed) mPtr = ea & 32'hFFFFFFF0;
    if (sr) {mBase, mPtr} = '0;
    @(negedge ref_clk);
    check({31'h0, rsp.rdValid}, {31'h0, mRv});
    check(rsp.rdData, mRd);
    check(intEnable, mEn);
    check(commAreaBaseAddress, mBase);
  endtask
  task automatic rand_steps(input int n);
    logic [31:0] r, d;
    logic [7:0] a;
    for (int i = 0; i < n; i++) begin
      r = rnd();
      a = addrTab[r[2:0]];
      // Reserved bits are written only as zero at the clear and comm-base offsets
      d = rnd() & (a == 8'h14 ? oir_pkg::ENABLE_IMPL_MASK :
        a == 8'h18 ? oir_pkg::COMM_BASE_MASK : 32'hFFFFFFFF);
      step(r[3], r[4] & (r[15:8] != 0), a, d, r[5] & r[6],
        rnd(), r[7], rnd(), r[15:8] == 0);
    end
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    check(intEnable, 32'h0);
    foreach (bits[i]) begin
      step(0, 0, 0, 0, 1, 32'hFFFFFFFF, 0, 0, 0);
      step(1, 0, 8'h14, 32'h1 << bits[i], 0, 0, 0, 0, 0);
      step(0, 1, 8'h14, 0, 0, 0, 0, 0, 0);
    end
    step(1, 0, 8'h18, 32'hFFFFFFFF, 0, 0, 0, 0, 0);
    step(0, 1, 8'h18, 0, 0, 0, 0, 0, 0);
    step(1, 0, 8'h1C, 32'hFFFFFFFF, 0, 0, 1, 32'h1234567F, 0);
    step(0, 1, 8'h1C, 0, 0, 0, 0, 0, 0);
    rand_steps(1500);
    // Hardware reset in mid-run
    rst = 1'b1;
    req = '0;
    core = '0;
    swReset = 1'b0;
    {mEn, mBase, mPtr} = '0;
    @(negedge ref_clk);
    check(intEnable | commAreaBaseAddress, 32'h0);
    check({31'h0, rsp.rdValid}, 32'h0);
    rst = 1'b0;
    step(0, 1, 8'h1C, 0, 0, 0, 0, 0, 0);
    rand_steps(500);
    wrap_up();
  end
  // Whole run is about 2100 cycles; allow roughly four times that
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
endmodule
